/* hdl/dkac_pkg.sv */
// package for the debug key access control block
package dkac_pkg;
  // register offsets
  localparam logic [7:0] KEY_STATUS_OFF = 8'h07;
  localparam logic [7:0] RESET_REQ_OFF  = 8'h08;
  localparam logic [7:0] SYS_CTRL_OFF   = 8'h0a;
  localparam logic [7:0] SYS_STATUS_OFF = 8'h0b;
  // key register field positions
  localparam int UROW_KEY_BIT  = 5;
  localparam int NVM_KEY_BIT   = 4;
  localparam int ERASE_KEY_BIT = 3;
  // system control fields
  localparam int USER_ROW_DONE_BIT = 1;
  localparam int CLOCK_HOLD_BIT    = 0;
  // system status fields
  localparam int RST_SYS_BIT   = 5;
  localparam int ASLEEP_BIT    = 4;
  localparam int NVM_GRANT_BIT = 3;
  localparam int UROW_GRANT_BIT= 2;
  localparam int LOCK_BIT      = 0;
  // reset values
  localparam logic       CLOCK_HOLD_RST = 1'b1;
  localparam logic [7:0] RESET_REQ_RST  = 8'h00;
  // key signatures
  localparam logic [63:0] ERASE_SIG = 64'h4e564d4572617365;
  localparam logic [63:0] NVM_SIG   = 64'h4e564d50726f6720;
  localparam logic [63:0] UROW_SIG  = 64'h4e564d5573267465;
  localparam int KEY_BYTES  = 8;
  localparam int UROW_BYTES = 32;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } dkac_reg_req_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic       wr;
  } dkac_ram_wr_t;
endpackage

/* hdl/dkac_top.sv */
// key protected access control of the single wire debug port
// Operation
// - erase key starts full chip erase clearing lock; port disable or reset drops it
// - nvm key acts only when unlocked and grant set; dropped on done or reset
// - user-row key acts only when locked with grant; dropped by status write/reset
// - keys are 64-bit, least byte first, compared with three fixed signatures
// - system bus refused until lock cleared; only control space allowed
// - brownout detector forced on during chip erase at configured level
// - direct nvm or flash writes from port only when unlocked
// - user-row mode accepts only ram writes below 32 bytes; others dropped
// - on completion staged bytes copy one to one into user row
// - done bit starts copy; device then clears user-row grant
// - no ram contents returned to the port in user-row mode
// - one-cycle pulse event on every sync character rising edge, cannot be disabled
// - port consumes no events; generator only
// - physical layer keeps operating in every sleep mode
// - no system bus access while system clock is stopped
// - system-asleep flag readable by programmer
// - clock hold keeps system clock during sleep, emulating sleep
// - clock hold defaults to one while port enabled
// - key load carries exactly 64 bits
// - user-row key flag set on decode; write to it resets session
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module dkac_top #(
  parameter logic [7:0] RESET_SIG = 8'h59
) (
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  // register port
  input  wire dkac_pkg::dkac_reg_req_t i_reg,
  output logic [7:0]                  o_rdata,
  // key load: one byte per strobe, last marks the eighth byte
  input  wire logic                   i_key_valid,
  input  wire logic [7:0]             i_key_byte,
  input  wire logic                   i_key_last,
  // port control
  input  wire logic                   i_port_disable,
  input  wire logic                   i_sync_pin,
  // system side status
  input  wire logic                   i_locked,
  input  wire logic                   i_sys_asleep,
  input  wire logic                   i_sys_clk_on,
  input  wire logic                   i_erase_done,
  input  wire logic                   i_nvm_done,
  // staging buffer, ram read, bus and nvm write requests from the access layer
  input  wire dkac_pkg::dkac_ram_wr_t i_ram_wr,
  input  wire logic                   i_ram_rd,
  input  wire logic                   i_bus_req,
  input  wire logic                   i_nvm_wr_req,
  // outputs
  output logic                        o_sys_reset,
  output logic                        o_chip_erase,
  output logic                        o_bod_force,
  output logic                        o_nvm_prog,
  output logic                        o_bus_grant,
  output logic                        o_nvm_wr_grant,
  output logic                        o_ram_rd_ok,
  output logic                        o_row_wr,
  output logic [4:0]                  o_row_addr,
  output logic [7:0]                  o_row_data,
  output logic                        o_clock_hold,
  output logic                        o_sync_event
);
  logic [63:0] shift_r;
  logic [3:0]  kcnt_r;
  logic        erase_key_r, nvm_key_r, urow_key_r;
  logic [7:0]  system_reset_request_r;
  logic        hold_r, nvm_grant_r, urow_grant_r, copying_r, erase_run_r;
  logic [5:0]  copy_idx_r;
  logic [7:0]  stage_r [dkac_pkg::UROW_BYTES];
  logic [dkac_pkg::SYNC_STAGES-1:0] sync_r;
  logic        sync_q_r;
  logic        wr_key, wr_rst, wr_ctl, key_done, port_reset;

  // zero is the release value, so it cannot also be the hold signature
  if (RESET_SIG == 8'h00)
  begin : g_bad_sig
    $error("reset signature must be nonzero");
  end

  assign wr_key = i_reg.wr && i_reg.addr == dkac_pkg::KEY_STATUS_OFF;
  assign wr_rst = i_reg.wr && i_reg.addr == dkac_pkg::RESET_REQ_OFF;
  assign wr_ctl = i_reg.wr && i_reg.addr == dkac_pkg::SYS_CTRL_OFF;
  assign key_done = i_key_valid && i_key_last && kcnt_r == 4'd7;
  assign port_reset = i_port_disable;

  // key shift: low byte arrives first, so bytes enter at the top
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      shift_r <= 64'h0;
      kcnt_r  <= 4'h0;
    end
    else if (i_key_valid)
    begin
      shift_r <= {i_key_byte, shift_r[63:8]};
      kcnt_r  <= i_key_last ? 4'h0 : kcnt_r + 4'h1;
    end
  end

  // erase key
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      erase_key_r <= 1'b0;
    else if (port_reset)
      erase_key_r <= 1'b0;
    else if (key_done && {i_key_byte, shift_r[63:8]} == dkac_pkg::ERASE_SIG)
      erase_key_r <= 1'b1;
  end

  // nvm key
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      nvm_key_r <= 1'b0;
    else if (port_reset || (nvm_key_r && i_nvm_done))
      nvm_key_r <= 1'b0;
    else if (key_done && {i_key_byte, shift_r[63:8]} == dkac_pkg::NVM_SIG)
      nvm_key_r <= 1'b1;
  end

  // user-row key; decode wins over a same-cycle status write
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      urow_key_r <= 1'b0;
    else if (key_done && {i_key_byte, shift_r[63:8]} == dkac_pkg::UROW_SIG)
      urow_key_r <= 1'b1;
    else if (port_reset || wr_key)
      urow_key_r <= 1'b0;
  end

  // reset request register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      system_reset_request_r <= dkac_pkg::RESET_REQ_RST;
    else if (port_reset)
      system_reset_request_r <= dkac_pkg::RESET_REQ_RST;
    else if (wr_rst)
      system_reset_request_r <= i_reg.data;
  end

  // clock hold; back to one whenever the port is disabled
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      hold_r <= dkac_pkg::CLOCK_HOLD_RST;
    else if (port_reset)
      hold_r <= dkac_pkg::CLOCK_HOLD_RST;
    else if (wr_ctl)
      hold_r <= i_reg.data[dkac_pkg::CLOCK_HOLD_BIT];
  end

  // grants are taken while system reset is held with the key active
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      nvm_grant_r  <= 1'b0;
      urow_grant_r <= 1'b0;
      erase_run_r  <= 1'b0;
    end
    else
    begin
      if (system_reset_request_r == RESET_SIG && erase_key_r)
        erase_run_r <= 1'b1;
      else if (i_erase_done)
        erase_run_r <= 1'b0;
      if (!nvm_key_r)
        nvm_grant_r <= 1'b0;
      else if (system_reset_request_r == RESET_SIG && !i_locked)
        nvm_grant_r <= 1'b1;
      if (!urow_key_r || (copying_r && copy_idx_r == 6'd31))
        urow_grant_r <= 1'b0;
      else if (system_reset_request_r == RESET_SIG && i_locked)
        urow_grant_r <= 1'b1;
    end
  end

  // staging buffer, write only in user-row mode
  for (genvar g = 0; g < dkac_pkg::UROW_BYTES; g++)
  begin : g_stage
    always_ff @(posedge i_clock or posedge i_rst)
    begin
      if (i_rst)
        stage_r[g] <= 8'h00;
      else if (urow_grant_r && !copying_r && i_ram_wr.wr && i_ram_wr.addr == 5'(g))
        stage_r[g] <= i_ram_wr.data;
    end
  end

  // copy sequence
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      copying_r  <= 1'b0;
      copy_idx_r <= 6'h0;
      o_row_wr   <= 1'b0;
      o_row_addr <= 5'h0;
      o_row_data <= 8'h00;
    end
    else
    begin
      o_row_wr <= copying_r;
      o_row_addr <= copy_idx_r[4:0];
      o_row_data <= stage_r[copy_idx_r[4:0]];
      if (wr_ctl && i_reg.data[dkac_pkg::USER_ROW_DONE_BIT] && urow_grant_r && !copying_r)
      begin
        copying_r  <= 1'b1;
        copy_idx_r <= 6'h0;
      end
      else if (copying_r)
      begin
        copy_idx_r <= copy_idx_r + 6'h1;
        if (copy_idx_r == 6'd31)
          copying_r <= 1'b0;
      end
    end
  end

  // sync event: three stages, edge when second and third agree on rise
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_r   <= '0;
      sync_q_r <= 1'b0;
      o_sync_event <= 1'b0;
    end
    else
    begin
      sync_r   <= {sync_r[1:0], i_sync_pin};
      if (sync_r[2] == sync_r[1])
        sync_q_r <= sync_r[2];
      o_sync_event <= (sync_r[2] == sync_r[1]) && sync_r[2] && !sync_q_r;
    end
  end

  // outputs and read port; no event input exists, generator only
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata        <= 8'h00;
      o_sys_reset    <= 1'b0;
      o_chip_erase   <= 1'b0;
      o_bod_force    <= 1'b0;
      o_nvm_prog     <= 1'b0;
      o_bus_grant    <= 1'b0;
      o_nvm_wr_grant <= 1'b0;
      o_ram_rd_ok    <= 1'b0;
      o_clock_hold   <= dkac_pkg::CLOCK_HOLD_RST;
    end
    else
    begin
      o_sys_reset  <= system_reset_request_r == RESET_SIG;
      o_chip_erase <= erase_run_r;
      o_bod_force  <= erase_run_r;
      o_nvm_prog   <= nvm_grant_r && !i_locked;
      o_bus_grant  <= i_bus_req && !i_locked && (i_sys_clk_on || hold_r);
      o_nvm_wr_grant <= i_nvm_wr_req && !i_locked;
      o_ram_rd_ok  <= i_ram_rd && !urow_grant_r && !i_locked;
      o_clock_hold <= hold_r;
      o_rdata      <= 8'h00;
      if (i_reg.rd)
      begin
        unique case (i_reg.addr)
          dkac_pkg::KEY_STATUS_OFF:
            o_rdata <= {2'b00, urow_key_r, nvm_key_r, erase_key_r, 3'b000};
          dkac_pkg::RESET_REQ_OFF:
            o_rdata <= system_reset_request_r;
          dkac_pkg::SYS_CTRL_OFF:
            o_rdata <= {7'h00, hold_r};
          dkac_pkg::SYS_STATUS_OFF:
            o_rdata <= {2'b00, system_reset_request_r == RESET_SIG, i_sys_asleep && !hold_r,
                        nvm_grant_r, urow_grant_r, 1'b0, i_locked};
          default:
            o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* tb/dkac_checker.sv */
// concurrent checks on the debug key access control ports
`timescale 1ns/1ps
module dkac_checker (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // inputs
  input wire logic       i_locked,
  input wire logic       i_sys_clk_on,
  input wire logic       i_port_disable,
  // outputs
  input wire logic       o_chip_erase,
  input wire logic       o_bod_force,
  input wire logic       o_bus_grant,
  input wire logic       o_nvm_wr_grant,
  input wire logic       o_ram_rd_ok,
  input wire logic       o_row_wr,
  input wire logic [4:0] o_row_addr,
  input wire logic       o_clock_hold,
  input wire logic       o_sync_event
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_bod; o_chip_erase |-> o_bod_force; endproperty
  a_bod: assert property (p_bod) else $error("erase without brownout");
  property p_bus; o_bus_grant |-> !$past(i_locked); endproperty
  a_bus: assert property (p_bus) else $error("bus granted while locked");
  property p_clk; o_bus_grant |-> $past(i_sys_clk_on) || o_clock_hold; endproperty
  a_clk: assert property (p_clk) else $error("bus granted without clock");
  property p_nvw; o_nvm_wr_grant |-> !$past(i_locked); endproperty
  a_nvw: assert property (p_nvw) else $error("nvm write while locked");
  property p_ram; o_ram_rd_ok |-> !$past(i_locked) && !o_row_wr; endproperty
  a_ram: assert property (p_ram) else $error("ram read in row mode");
  property p_row; o_row_wr && o_row_addr != 5'h1f |=> o_row_wr && o_row_addr == $past(o_row_addr) + 5'h01; endproperty
  a_row: assert property (p_row) else $error("row copy out of order");
  property p_hld; i_port_disable |-> ##2 o_clock_hold && !o_chip_erase; endproperty
  a_hld: assert property (p_hld) else $error("disable left state");
  property p_syn; o_sync_event |=> !o_sync_event; endproperty
  a_syn: assert property (p_syn) else $error("sync event too long");
  c_row: cover property (o_row_wr && o_row_addr == 5'h1f);
  c_era: cover property (o_chip_erase);
  c_syn: cover property (o_sync_event);
endmodule

bind dkac_top dkac_checker chk (.i_clock, .i_rst, .i_locked, .i_sys_clk_on, .i_port_disable, .o_chip_erase,
  .o_bod_force, .o_bus_grant, .o_nvm_wr_grant, .o_ram_rd_ok, .o_row_wr, .o_row_addr, .o_clock_hold, .o_sync_event);

/* tb/dkac_prog_model.sv */
// programmer model: register port cycles and key loads
`timescale 1ns/1ps
module dkac_prog_model #(
  parameter logic [7:0] RESET_SIG = 8'h59
) (
  // clock
  input  wire logic              i_clock,
  // register port
  output dkac_pkg::dkac_reg_req_t o_reg,
  input  wire logic [7:0]        i_rdata,
  // key load
  output logic                   o_key_valid,
  output logic [7:0]             o_key_byte,
  output logic                   o_key_last
);
  initial
  begin
    o_reg = '{8'hff, 8'hff, 1'b0, 1'b0};
    o_key_valid = 1'b0;
    o_key_byte = 8'hff;
    o_key_last = 1'b0;
  end
  // released fields flip so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_reg <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clock);
    o_reg <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_reg <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clock);
    o_reg <= '{~a, 8'hff, 1'b0, 1'b0};
    @(posedge i_clock);
    d = i_rdata;
  endtask
  // low byte first; any count but eight is a malformed key
  task automatic key(input logic [63:0] k, input int nb);
    for (int i = 0; i < nb; i++)
    begin
      @(posedge i_clock);
      o_key_valid <= 1'b1;
      o_key_byte <= k[8*i +: 8];
      o_key_last <= (i == nb - 1);
    end
    @(posedge i_clock);
    o_key_valid <= 1'b0;
    o_key_byte <= ~o_key_byte;
    o_key_last <= 1'b0;
  endtask
  task automatic pulse_reset();
    wr(dkac_pkg::RESET_REQ_OFF, RESET_SIG);
    wr(dkac_pkg::RESET_REQ_OFF, 8'h00);
  endtask
endmodule

/* tb/tb_debug_key_access_control.sv */
// self-checking bench for the debug key access control block
`timescale 1ns/1ps
module tb_debug_key_access_control;
  localparam logic [7:0] SIG = 8'h59;
  logic i_clock = 1'b0, i_rst = 1'b1, dis = 1'b0, syn = 1'b0, lock = 1'b1, slp = 1'b0, con = 1'b1;
  logic edn = 1'b0, ndn = 1'b0, rrd = 1'b0, brq = 1'b0, nrq = 1'b0, kv, kl;
  logic erase, brownout_detector, nvp, bus_g, nvw_g, ram_ok, row_wr, hold, sev, srst;
  logic [7:0] rdata, rd_v, kb, row_d;
  logic [4:0] row_a;
  dkac_pkg::dkac_reg_req_t rq;
  dkac_pkg::dkac_ram_wr_t  rw = '0;
  int errors = 0, cmp_count = 0, n;
  dkac_top #(.RESET_SIG(SIG)) uut (.i_clock, .i_rst, .i_reg(rq), .o_rdata(rdata), .i_key_valid(kv),
    .i_key_byte(kb), .i_key_last(kl), .i_port_disable(dis), .i_sync_pin(syn), .i_locked(lock),
    .i_sys_asleep(slp), .i_sys_clk_on(con), .i_erase_done(edn), .i_nvm_done(ndn), .i_ram_wr(rw),
    .i_ram_rd(rrd), .i_bus_req(brq), .i_nvm_wr_req(nrq), .o_sys_reset(srst), .o_chip_erase(erase),
    .o_bod_force(brownout_detector), .o_nvm_prog(nvp), .o_bus_grant(bus_g), .o_nvm_wr_grant(nvw_g), .o_ram_rd_ok(ram_ok),
    .o_row_wr(row_wr), .o_row_addr(row_a), .o_row_data(row_d), .o_clock_hold(hold), .o_sync_event(sev));
  dkac_prog_model #(.RESET_SIG(SIG)) prog (.i_clock, .o_reg(rq), .i_rdata(rdata), .o_key_valid(kv),
    .o_key_byte(kb), .o_key_last(kl));
  initial forever #5 i_clock = ~i_clock;
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    prog.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic t_erase();
    prog.key(dkac_pkg::ERASE_SIG, 8);
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h08);
    @(posedge i_clock) {brq, nrq} <= 2'b11;
    @(negedge i_clock) chk({bus_g, nvw_g}, 8'h00);
    prog.wr(dkac_pkg::RESET_REQ_OFF, SIG);
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h21);
    chk({erase, brownout_detector}, 8'h03);
    prog.wr(dkac_pkg::RESET_REQ_OFF, 8'h00);
    @(posedge i_clock) {edn, lock} <= 2'b10;
    @(posedge i_clock) edn <= 1'b0;
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h00);
    chk({bus_g, nvw_g, erase}, 8'h06);
  endtask
  task automatic t_sleep();
    @(posedge i_clock) {con, slp} <= 2'b01;
    prog.wr(dkac_pkg::SYS_CTRL_OFF, 8'h00);
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h10);
    chk({bus_g, hold}, 8'h00);
    @(posedge i_clock) dis <= 1'b1;
    @(posedge i_clock) dis <= 1'b0;
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h00);
    rchk(dkac_pkg::SYS_CTRL_OFF, 8'h01);
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h00);
    @(posedge i_clock) {con, slp} <= 2'b10;
  endtask
  task automatic t_nvm();
    prog.key(dkac_pkg::NVM_SIG, 8);
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h10);
    prog.pulse_reset();
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h08);
    chk(8'(nvp), 8'h01);
    @(posedge i_clock) ndn <= 1'b1;
    @(posedge i_clock) ndn <= 1'b0;
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h00);
  endtask
  task automatic t_urow();
    @(posedge i_clock) lock <= 1'b1;
    prog.key(dkac_pkg::UROW_SIG, 7);
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h00);
    prog.key(dkac_pkg::UROW_SIG, 8);
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h20);
    prog.pulse_reset();
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h05);
    for (int i = 0; i < 32; i++)
      @(posedge i_clock) rw <= '{5'(i), 8'(i) ^ 8'ha5, 1'b1};
    @(posedge i_clock) {rw.wr, rrd} <= 2'b01;
    @(negedge i_clock) chk(8'(ram_ok), 8'h00);
    n = 0;
    fork
      prog.wr(dkac_pkg::SYS_CTRL_OFF, 8'h03);
      repeat (40)
        @(negedge i_clock) if (row_wr === 1'b1)
        begin
          chk(row_d, {3'h0, row_a} ^ 8'ha5);
          n++;
        end
    join
    chk(8'(n), 8'h20);
    rchk(dkac_pkg::SYS_STATUS_OFF, 8'h01);
    prog.wr(dkac_pkg::KEY_STATUS_OFF, 8'h20);
    rchk(dkac_pkg::KEY_STATUS_OFF, 8'h00);
    prog.pulse_reset();
  endtask
  task automatic t_sync();
    n = 0;
    fork
      repeat (8)
      begin
        syn <= ~syn;
        repeat (4) @(posedge i_clock);
      end
      repeat (40) @(negedge i_clock) n += int'(sev === 1'b1);
    join
    chk(8'(n), 8'h04);
  endtask
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rchk(dkac_pkg::SYS_CTRL_OFF, 8'h01);
    t_erase();
    t_sleep();
    t_nvm();
    t_urow();
    t_sync();
    complete_run();
  end
  initial
  begin
    #500000;
    errors++;
    complete_run();
  end
endmodule
